/* File: src/fswp_defines.vh */
// constants for the flash status and write-protect block
`ifndef FSWP_DEFINES_VH
`define FSWP_DEFINES_VH
// command opcodes
`define FSWP_OP_WR_ENABLE 8'h06
`define FSWP_OP_WR_DISABLE 8'h04
`define FSWP_OP_RD_STATUS 8'h05
`define FSWP_OP_WR_STATUS 8'h01
`define FSWP_OP_PAGE_PROG 8'h02
`define FSWP_OP_SECT_ERASE 8'h20
`define FSWP_OP_BLK_ERASE_A 8'h52
`define FSWP_OP_BLK_ERASE_B 8'hD8
`define FSWP_OP_CHIP_ERASE_A 8'h60
`define FSWP_OP_CHIP_ERASE_B 8'hC7
// status field positions
`define FSWP_BUSY_BIT 0
`define FSWP_LATCH_BIT 1
`define FSWP_LVL_LSB 2
`define FSWP_LVL_MSB 5
`define FSWP_ZERO_BIT 6
`define FSWP_LOCK_BIT 7
// reset values of the non-volatile fields
`define FSWP_LVL_RST 4'h0
`define FSWP_LOCK_RST 1'b0
// frame lengths in serial clock edges
`define FSWP_BITS_OPCODE 6'd8
`define FSWP_BITS_STATUS 6'd16
`define FSWP_BITS_ADDR 6'd32
// timing: core clock period and status write time in ns
`define FSWP_CLK_NS 25
`define FSWP_STATUS_WRITE_TIME_NS 15000000
`define FSWP_STATUS_WRITE_CYC \
  ((`FSWP_STATUS_WRITE_TIME_NS + `FSWP_CLK_NS - 1) / `FSWP_CLK_NS)
`endif

/* File: src/fswp_status_protect.v */
// status register, write latch and protection logic of a serial flash
// Functional notes
// [RULE1] write-disable completion clears the write latch
// [RULE2] latch cleared at reset and after disable, status write, program, erase
// [RULE3] read-status answered at any time, repeating while clocks continue
// [RULE4] host should poll busy before new commands during operations
// [RULE5] status bit 0 is busy during program, erase or status write
// [RULE6] status bit 1 is the write latch; writes need it set
// [RULE7] program or erase on protected region ignored, latch unchanged
// [RULE8] bits 5..2 are protect level, changed only by write-status; the code also loads FSWP_LVL_RST into them at reset
// [RULE9] chip erase runs only when protect level is zero
// [RULE10] lock set with protect pin low refuses write-status
// [RULE11] bit 6 reads zero, bit 7 is the status lock bit
// [RULE12] write-status needs a prior write-enable; refused with latch clear
// [RULE13] write-status updates only lock and level bits
// [RULE14] write-status discarded unless select rises on a byte boundary
// [RULE15] timed status write starts at select rise, busy then latch clear
// [RULE16] lock clear, or lock set with pin high, allows status writes
// [RULE17] write-enable completion sets the write latch
// [RULE18] one opcode byte msb first on rising clock, then data bytes
// [RULE19] while busy, only status reads are accepted
`timescale 1ns/1ps
`include "fswp_defines.vh"
module fswp_status_protect #(
  parameter STATUS_WRITE_CYC = `FSWP_STATUS_WRITE_CYC,
  parameter CNT_W = 20
)(
  input wire core_clk,
  input wire nrst,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire wp_n,
  output wire spi_miso,
  output wire spi_miso_oe,
  output wire [7:0] status_out,
  output wire [3:0] protect_level_bits,
  output wire busy_flag,
  output wire write_latch_flag,
  output reg array_op_start,
  output reg [7:0] array_op_code,
  output reg [23:0] array_addr,
  input wire array_addr_protected,
  input wire array_op_done
);
  reg sclk_m_q, sclk_s_q, sclk_p_q;
  reg cs_m_q, cs_s_q, cs_p_q;
  reg mosi_m_q, mosi_s_q;
  reg wp_m_q, wp_s_q;
  reg [5:0] bit_cnt_q;
  reg [31:0] shift_q;
  reg [7:0] opcode_q;
  reg rd_active_q;
  reg [2:0] out_idx_q;
  reg [7:0] snap_q;
  reg miso_q;
  reg latch_q;
  reg [3:0] level_q;
  reg lock_q;
  reg [7:0] new_status_q;
  reg sw_busy_q;
  reg arr_busy_q;
  reg [CNT_W-1:0] sw_cnt_q;
  wire sclk_rise, sclk_fall, cs_rise, cs_low, busy, hw_protect;
  wire [5:0] bits_next;
  wire [7:0] status;

  // program, sector and block erase opcodes (not chip erase) that need the latch and a free region
  function is_array_write;
    input [7:0] op;
    begin
      is_array_write = (op == `FSWP_OP_PAGE_PROG) ||
        (op == `FSWP_OP_SECT_ERASE) || (op == `FSWP_OP_BLK_ERASE_A) ||
        (op == `FSWP_OP_BLK_ERASE_B);
    end
  endfunction

  function is_chip_erase;
    input [7:0] op;
    begin
      is_chip_erase = (op == `FSWP_OP_CHIP_ERASE_A) ||
        (op == `FSWP_OP_CHIP_ERASE_B);
    end
  endfunction

  // two-stage synchronisers; the third sclk/cs stage is for edge finding
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_p_q <= 1'b1;
      mosi_m_q <= 1'b0;
      mosi_s_q <= 1'b0;
      wp_m_q <= 1'b1;
      wp_s_q <= 1'b1;
    end
    else
    begin
      sclk_m_q <= spi_sclk;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      cs_m_q <= spi_cs_n;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      mosi_m_q <= spi_mosi;
      mosi_s_q <= mosi_m_q;
      wp_m_q <= wp_n;
      wp_s_q <= wp_m_q;
    end
  end

  assign cs_low = !cs_s_q;
  assign sclk_rise = cs_low && sclk_s_q && !sclk_p_q;
  assign sclk_fall = cs_low && !sclk_s_q && sclk_p_q;
  assign cs_rise = cs_s_q && !cs_p_q;
  assign bits_next = bit_cnt_q + 6'd1;
  assign busy = sw_busy_q || arr_busy_q;
  assign hw_protect = lock_q && !wp_s_q; // [RULE10]

  // live status image; bit 6 is hard zero
  assign status = {lock_q, 1'b0, level_q, latch_q, busy}; // [RULE11] [RULE5]

  // serial input: opcode then data, msb first on rising sclk
  always @(posedge core_clk)
  begin
    if (!nrst || !cs_low)
    begin
      bit_cnt_q <= 6'd0;
      shift_q <= 32'h0000_0000;
      opcode_q <= 8'h00;
      rd_active_q <= 1'b0;
    end
    else if (sclk_rise)
    begin
      shift_q <= {shift_q[30:0], mosi_s_q}; // [RULE18]
      // saturate so an overlong frame never looks like a boundary hit
      if (bit_cnt_q != 6'h3F)
        bit_cnt_q <= bits_next;
      if (bits_next == `FSWP_BITS_OPCODE)
      begin
        opcode_q <= {shift_q[6:0], mosi_s_q};
        if ({shift_q[6:0], mosi_s_q} == `FSWP_OP_RD_STATUS)
          rd_active_q <= 1'b1; // [RULE3]
      end
    end
  end

  // status readout on falling sclk, snapshot per byte, repeats forever
  always @(posedge core_clk)
  begin
    if (!nrst || !cs_low)
    begin
      out_idx_q <= 3'd7;
      snap_q <= 8'h00;
      miso_q <= 1'b0;
    end
    else if (sclk_fall && rd_active_q)
    begin
      out_idx_q <= out_idx_q - 3'd1; // [RULE3]
      if (out_idx_q == 3'd7)
      begin
        snap_q <= status;
        miso_q <= status[7];
      end
      else
        miso_q <= snap_q[out_idx_q];
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe = rd_active_q && cs_low;

  // command execution at select rise; frame length must match exactly
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      latch_q <= 1'b0; // [RULE2]
      level_q <= `FSWP_LVL_RST;
      lock_q <= `FSWP_LOCK_RST;
      new_status_q <= 8'h00;
      sw_busy_q <= 1'b0;
      sw_cnt_q <= {CNT_W{1'b0}};
      arr_busy_q <= 1'b0;
      array_op_start <= 1'b0;
      array_op_code <= 8'h00;
      array_addr <= 24'h00_0000;
    end
    else
    begin
      array_op_start <= 1'b0;
      // timed status write in progress
      if (sw_busy_q)
      begin
        if (sw_cnt_q == STATUS_WRITE_CYC[CNT_W-1:0] - 1'b1)
        begin
          sw_busy_q <= 1'b0; // [RULE15]
          lock_q <= new_status_q[`FSWP_LOCK_BIT]; // [RULE13] [RULE8]
          level_q <= new_status_q[`FSWP_LVL_MSB:`FSWP_LVL_LSB];
          latch_q <= 1'b0; // [RULE2]
        end
        else
          sw_cnt_q <= sw_cnt_q + 1'b1;
      end
      // array operation ends when the array side reports done
      if (arr_busy_q && array_op_done)
      begin
        arr_busy_q <= 1'b0;
        latch_q <= 1'b0; // [RULE2]
      end
      // busy refuses every new command except reads
      if (cs_rise && !busy) // [RULE19]
      begin
        if (bit_cnt_q == `FSWP_BITS_OPCODE &&
            opcode_q == `FSWP_OP_WR_ENABLE)
          latch_q <= 1'b1; // [RULE17]
        else if (bit_cnt_q == `FSWP_BITS_OPCODE &&
                 opcode_q == `FSWP_OP_WR_DISABLE)
          latch_q <= 1'b0; // [RULE1]
        else if (bit_cnt_q == `FSWP_BITS_STATUS &&
                 opcode_q == `FSWP_OP_WR_STATUS &&
                 latch_q && !hw_protect) // [RULE14] [RULE12] [RULE16]
        begin
          new_status_q <= shift_q[7:0];
          sw_busy_q <= 1'b1; // [RULE15]
          sw_cnt_q <= {CNT_W{1'b0}};
        end
        else if (bit_cnt_q == `FSWP_BITS_OPCODE &&
                 is_chip_erase(opcode_q) && latch_q &&
                 level_q == 4'h0) // [RULE9] [RULE6]
        begin
          arr_busy_q <= 1'b1;
          array_op_start <= 1'b1;
          array_op_code <= opcode_q;
          array_addr <= 24'h00_0000;
        end
        // protected target: ignored and the latch is left alone
        else if (bit_cnt_q == `FSWP_BITS_ADDR &&
                 is_array_write(opcode_q) && latch_q &&
                 !array_addr_protected) // [RULE7] [RULE6]
        begin
          arr_busy_q <= 1'b1;
          array_op_start <= 1'b1;
          array_op_code <= opcode_q;
          array_addr <= shift_q[23:0];
        end
      end
    end
  end

  // flags brought out straight from their registers
  assign status_out = status;
  assign protect_level_bits = level_q; // [RULE8]
  assign busy_flag = busy;
  assign write_latch_flag = latch_q;
endmodule

/* File: tb/fswp_asserts.sv */
// port assertions for the status and protect block
`timescale 1ns/1ps
`include "fswp_defines.vh"
module fswp_checker(
  input wire core_clk,
  input wire nrst,
  input wire spi_cs_n,
  input wire spi_miso_oe,
  input wire wp_n,
  input wire [7:0] status_out,
  input wire [3:0] protect_level_bits,
  input wire busy_flag,
  input wire write_latch_flag,
  input wire array_op_start,
  input wire [7:0] array_op_code,
  input wire array_addr_protected
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // status byte must mirror the live flags, bit 6 fixed low
  chk_status_layout: assert property (
    status_out[6:0] == {1'b0, protect_level_bits, write_latch_flag,
    busy_flag}) else $error("status byte layout wrong");
  // level only moves when a timed cycle ends
  chk_level_only_end: assert property (
    $changed(protect_level_bits) |-> $fell(busy_flag))
    else $error("protect level changed outside status write");
  // a status write may not start while locked with the pin low
  chk_hw_lock: assert property (
    $rose(busy_flag) && !array_op_start |-> !status_out[7] || wp_n)
    else $error("status write started in hardware protect");
  chk_latch_first: assert property (
    $rose(busy_flag) |-> $past(write_latch_flag))
    else $error("cycle started without write latch");
  // nothing may drop the latch mid-cycle
  chk_busy_keeps_latch: assert property (
    busy_flag |-> write_latch_flag)
    else $error("latch lost while busy");
  chk_latch_clear_end: assert property (
    $fell(busy_flag) |-> !write_latch_flag)
    else $error("latch kept after cycle end");
  chk_chip_erase_level: assert property (
    array_op_start && (array_op_code == `FSWP_OP_CHIP_ERASE_A ||
    array_op_code == `FSWP_OP_CHIP_ERASE_B) |-> protect_level_bits == 4'h0)
    else $error("chip erase with nonzero level");
  chk_protect_start: assert property (
    array_op_start |-> !array_addr_protected)
    else $error("op started on protected region");
  chk_read_drive: assert property (
    $rose(spi_miso_oe) |-> !spi_cs_n)
    else $error("miso driven while deselected");
endmodule
bind fswp_status_protect fswp_checker u_chk (
  .core_clk(core_clk), .nrst(nrst), .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe), .wp_n(wp_n), .status_out(status_out),
  .protect_level_bits(protect_level_bits), .busy_flag(busy_flag),
  .write_latch_flag(write_latch_flag), .array_op_start(array_op_start),
  .array_op_code(array_op_code),
  .array_addr_protected(array_addr_protected));

/* File: tb/fswp_host.sv */
// serial host model driving select, clock and data
`timescale 1ns/1ps
module fswp_host(
  input wire core_clk,
  input wire spi_miso,
  output reg spi_sclk,
  output reg spi_cs_n,
  output reg spi_mosi
);
  reg [31:0] rx;
  initial {spi_sclk, spi_cs_n, spi_mosi} = 3'b010;
  // mode 0 frame, clock idles low between frames
  task frame(input [31:0] d, input integer n);
    integer k;
    begin
      repeat (4) @(posedge core_clk);
      spi_cs_n <= 1'b0;
      for (k = n - 1; k >= 0; k = k - 1)
      begin
        spi_mosi <= d[k];
        repeat (4) @(posedge core_clk);
        spi_sclk <= 1'b1;
        repeat (4) @(posedge core_clk);
        rx <= {rx[30:0], spi_miso};
        spi_sclk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      spi_cs_n <= 1'b1;
      spi_mosi <= ~spi_mosi; // released line shows no stale bit
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the status and protect block
`timescale 1ns/1ps
module tb_top;
  localparam NR = 25;
  // pin nibble {wp_n, protected}, frame, bit count, expected status
  localparam [NR*52-1:0] ROWS = {
    52'h2_00000006_08_02, 52'h2_00000004_08_00, 52'h2_000001BC_10_00,
    52'h2_00000006_08_02, 52'h2_000001FF_10_BC, 52'h2_00000006_08_BE,
    52'h2_00000060_08_BE, 52'h2_00000100_10_00, 52'h2_00000006_08_02,
    52'h2_000000C7_08_00, 52'h2_00000006_08_02, 52'h2_02123456_20_00,
    52'h2_00000006_08_02, 52'h3_20001000_20_02, 52'h2_20001000_20_00,
    52'h2_00000006_08_02, 52'h2_52010000_20_00, 52'h2_00000006_08_02,
    52'h2_D8020000_20_00, 52'h2_00000006_08_02, 52'h2_00000180_10_80,
    52'h0_00000006_08_82, 52'h0_00000100_10_82, 52'h2_00000080_0F_82,
    52'h2_00000100_10_00};
  reg core_clk, nrst, wp_n, array_addr_protected, array_op_done;
  reg [51:0] r;
  integer i, k, error_cnt, check_count;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, busy_flag, array_op_start;
  wire [7:0] status_out;
  wire [7:0] op_code;
  wire [23:0] op_addr;
  fswp_status_protect #(.STATUS_WRITE_CYC(200)) DUT (
    .core_clk(core_clk), .nrst(nrst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n),
    .spi_miso(spi_miso), .spi_miso_oe(), .status_out(status_out),
    .protect_level_bits(), .busy_flag(busy_flag), .write_latch_flag(),
    .array_op_start(array_op_start), .array_op_code(op_code),
    .array_addr(op_addr),
    .array_addr_protected(array_addr_protected),
    .array_op_done(array_op_done));
  fswp_host host (.core_clk(core_clk), .spi_miso(spi_miso),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  always #12.5 core_clk = ~core_clk;
  // array side finishes every started op one cycle later
  always @(posedge core_clk) array_op_done <= array_op_start;
  task check(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      if (got !== exp)
        error_cnt = error_cnt + 1;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // bounded wait for the busy flag to drop, then read status
  task idle_read;
    begin
      k = 0;
      repeat (8) @(posedge core_clk);
      while (busy_flag !== 1'b0 && k < 2000)
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      if (k == 2000)
        error_cnt = error_cnt + 1;
      if (k == 2000)
        complete_run;
      host.frame(32'h0500, 16);
    end
  endtask
  initial
  begin
    core_clk = 1'b0;
    nrst = 1'b0;
    wp_n = 1'b1;
    array_addr_protected = 1'b0;
    array_op_done = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    check(status_out, 8'h00);
    $display("reset test done");
    for (i = 0; i < NR; i = i + 1)
    begin
      r = ROWS[(NR - 1 - i) * 52 +: 52];
      wp_n <= r[49];
      array_addr_protected <= r[48];
      host.frame(r[47:16], r[15:8]);
      idle_read;
      check(host.rx[7:0], r[7:0]);
      check(status_out, r[7:0]);
      $display("row %0d done", i);
    end
    // last started op was the block erase at 0x020000
    check(op_code, 8'hD8);
    check(op_addr[23:16], 8'h02);
    check(op_addr[15:8], 8'h00);
    // status polled twice within one read while a write runs
    host.frame(32'h06, 8);
    host.frame(32'h0104, 16);
    host.frame(32'h050000, 24);
    check(host.rx[15:8], 8'h03);
    check(host.rx[7:0], 8'h03);
    idle_read;
    check(host.rx[7:0], 8'h04);
    $display("busy read test done");
    // second reset with level set, applied before the write-enable just sent takes effect
    host.frame(32'h06, 8);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(status_out, 8'h00);
    nrst <= 1'b1;
    host.frame(32'h06, 8);
    idle_read;
    check(host.rx[7:0], 8'h02);
    $display("mid reset test done");
    complete_run;
  end
endmodule
